// ===== serial_an_regs.sv
// control and status bank of the serial system-side interface
// assumes link status inputs from another clock; bus and receive on i_sys_clk
`timescale 1ns/1ps
module serial_an_regs
    import serial_an_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic [4:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    input wire logic [2:0] i_strap_mode,
    input wire logic i_sync,
    input wire logic i_link_sm_up,
    input wire logic i_an_enable,
    input wire logic i_local_np_able,
    input wire logic i_page_valid,
    input wire logic i_lp_np_able,
    input wire logic i_cfg_valid,
    input wire logic [15:0] i_cfg_word,
    input wire logic [9:0] i_serial_rx,
    input wire logic [9:0] i_core_tx,
    output logic [9:0] o_serial_tx,
    output logic o_link_up,
    output logic o_bypass_active,
    output logic o_media_role,
    output logic o_irq
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] sync_a_r;
    logic [2:0] sync_b_r;
    logic [2:0] pin_raw;
    assign pin_raw = {i_sync, i_link_sm_up, i_an_enable};

    // two stage synchroniser, first stage read only by the second
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_sync
            always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
                if (!i_rst_n) begin
                    sync_a_r[g] <= 1'b0;
                    sync_b_r[g] <= 1'b0;
                end else begin
                    sync_a_r[g] <= pin_raw[g];
                    sync_b_r[g] <= sync_a_r[g];
                end
            end
        end
    endgenerate

    logic sync_s;
    logic link_sm_s;
    logic an_en_s;
    assign sync_s = sync_b_r[2];
    assign link_sm_s = sync_b_r[1];
    assign an_en_s = sync_b_r[0];

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    function automatic logic hit(input logic [4:0] a, input logic [4:0] r);
        hit = (a == r);
    endfunction : hit

    logic wr_ctl;
    logic wr_swr;
    logic wr_ists;
    logic wr_imsk;
    logic rd_exp;
    assign wr_ctl = i_wr && hit(i_addr, ADDR_CONTROL_ONE);
    assign wr_swr = i_wr && hit(i_addr, ADDR_SWRESET) && i_wdata[SWR_GO];
    assign wr_ists = i_wr && hit(i_addr, ADDR_INT_STATUS);
    assign wr_imsk = i_wr && hit(i_addr, ADDR_INT_MASK);
    assign rd_exp = i_rd && hit(i_addr, ADDR_EXPANSION);

    // ------------------------------------------------------------
    // partner ability detection
    // ------------------------------------------------------------
    logic matched;
    cfg_match_counter u_match (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n),
        .i_clear(!sync_s || wr_swr),
        .i_cfg_valid(i_cfg_valid),
        .i_cfg_word(i_cfg_word),
        .o_matched(matched)
    );

    // ------------------------------------------------------------
    // control and expansion state
    // ------------------------------------------------------------
    logic [15:0] ctl_r;
    logic [15:0] ctl_nxt;
    logic bypass_act_r;
    logic bypass_act_nxt;
    logic role_act_r;
    logic role_act_nxt;
    logic strap_done_r;
    logic strap_done_nxt;
    logic page_rx_r;
    logic page_rx_nxt;
    logic lp_np_r;
    logic lp_np_nxt;
    logic lp_an;

    assign lp_an = sync_s && matched && an_en_s;

    // control writes, strap capture and software reset effects
    always_comb begin
        ctl_nxt = ctl_r;
        bypass_act_nxt = bypass_act_r;
        role_act_nxt = role_act_r;
        strap_done_nxt = 1'b1;
        if (!strap_done_r) begin
            ctl_nxt[CTL_ROLE] = (i_strap_mode == STRAP_MEDIA);
            role_act_nxt = (i_strap_mode == STRAP_MEDIA);
        end else if (wr_ctl) begin
            ctl_nxt = (i_wdata & CTL_WMASK) | (ctl_r & ~CTL_WMASK);
        end
        if (wr_swr) begin
            ctl_nxt[CTL_LOOPBACK] = 1'b0;
            bypass_act_nxt = ctl_r[CTL_BYPASS];
            role_act_nxt = ctl_r[CTL_ROLE];
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ctl_r <= CTL_RESET;
            bypass_act_r <= 1'b1;
            role_act_r <= 1'b0;
            strap_done_r <= 1'b0;
        end else begin
            ctl_r <= ctl_nxt;
            bypass_act_r <= bypass_act_nxt;
            role_act_r <= role_act_nxt;
            strap_done_r <= strap_done_nxt;
        end
    end

    // page latch: arrival wins over the clearing read
    always_comb begin
        page_rx_nxt = page_rx_r;
        lp_np_nxt = lp_np_r;
        if (rd_exp || wr_swr) begin
            page_rx_nxt = 1'b0;
        end
        if (i_page_valid) begin
            page_rx_nxt = 1'b1;
            lp_np_nxt = i_lp_np_able;
        end
        if (!sync_s) begin
            lp_np_nxt = 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            page_rx_r <= 1'b0;
            lp_np_r <= 1'b0;
        end else begin
            page_rx_r <= page_rx_nxt;
            lp_np_r <= lp_np_nxt;
        end
    end

    // ------------------------------------------------------------
    // interrupts
    // ------------------------------------------------------------
    logic [2:0] ists_r;
    logic [2:0] ists_nxt;
    logic [2:0] imsk_r;
    logic [2:0] imsk_nxt;
    logic lp_an_d_r;
    logic link_d_r;
    logic [2:0] ev;

    assign ev = {o_link_up && !link_d_r, lp_an && !lp_an_d_r, i_page_valid};

    // sticky status, write one clears, a new event wins
    always_comb begin
        ists_nxt = ists_r;
        imsk_nxt = imsk_r;
        if (wr_ists) begin
            ists_nxt = ists_r & ~i_wdata[2:0];
        end
        ists_nxt = ists_nxt | ev;
        if (wr_imsk) begin
            imsk_nxt = i_wdata[2:0] & EV_ALL;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ists_r <= 3'h0;
            imsk_r <= 3'h0;
            lp_an_d_r <= 1'b0;
            link_d_r <= 1'b0;
        end else begin
            ists_r <= ists_nxt;
            imsk_r <= imsk_nxt;
            lp_an_d_r <= lp_an;
            link_d_r <= o_link_up;
        end
    end

    assign o_irq = |(ists_r & imsk_r);

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;

    // read mux, unmapped addresses read zero
    always_comb begin
        rdata_nxt = 16'h0000;
        if (i_rd) begin
            case (i_addr)
                ADDR_EXPANSION: begin
                    rdata_nxt[EXP_LP_NP] = lp_np_r;
                    rdata_nxt[EXP_LOCAL_NP] = i_local_np_able;
                    rdata_nxt[EXP_PAGE_RX] = page_rx_r;
                    rdata_nxt[EXP_LP_AN] = lp_an; // upper bits zero
                end
                ADDR_CONTROL_ONE: rdata_nxt = ctl_r & CTL_WMASK;
                ADDR_INT_STATUS: rdata_nxt = {13'h0000, ists_r};
                ADDR_INT_MASK: rdata_nxt = {13'h0000, imsk_r};
                default: rdata_nxt = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_r <= 16'h0000;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign o_rdata = rdata_r;

    // ------------------------------------------------------------
    // datapath and link
    // ------------------------------------------------------------
    logic [9:0] tx_r;
    logic [9:0] tx_nxt;
    logic link_r;
    logic link_nxt;

    // loopback select and forced link
    always_comb begin
        tx_nxt = ctl_r[CTL_LOOPBACK] ? i_serial_rx : i_core_tx;
        link_nxt = ctl_r[CTL_FORCE_LINK] ? 1'b1 : link_sm_s;
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tx_r <= 10'h000;
            link_r <= 1'b0;
        end else begin
            tx_r <= tx_nxt;
            link_r <= link_nxt;
        end
    end

    assign o_serial_tx = tx_r;
    assign o_link_up = link_r;
    assign o_bypass_active = bypass_act_r;
    assign o_media_role = role_act_r;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_rst_n);

    chk_lp_np_read: assert property (rd_exp |=> o_rdata[EXP_LP_NP] == $past(lp_np_r))
        else $error("partner next page bit wrong");
    chk_local_np_read: assert property (
        rd_exp |=> o_rdata[EXP_LOCAL_NP] == $past(i_local_np_able))
        else $error("local next page bit wrong");
    chk_page_latch: assert property (i_page_valid |=> page_rx_r)
        else $error("page not latched");
    chk_lp_an_cond: assert property (
        rd_exp && !(sync_s && matched && an_en_s) |=> !o_rdata[EXP_LP_AN])
        else $error("partner able without conditions");
    chk_loopback_path: assert property (
        ctl_r[CTL_LOOPBACK] |=> o_serial_tx == $past(i_serial_rx))
        else $error("loopback data wrong");
    chk_force_link: assert property (ctl_r[CTL_FORCE_LINK] |=> o_link_up)
        else $error("forced link not up");
    chk_bypass_hold: assert property (!wr_swr |=> $stable(o_bypass_active))
        else $error("bypass changed without reset");
    chk_role_hold: assert property (strap_done_r && !wr_swr |=> $stable(o_media_role))
        else $error("role changed without reset");
    chk_page_clear: assert property (
        page_rx_r && rd_exp && !i_page_valid ##1 !i_page_valid |=> !page_rx_r)
        else $error("page latch not cleared by read");
    chk_reserved_zero: assert property (rd_exp |=> o_rdata[15:4] == 12'h000)
        else $error("reserved bits nonzero");
    chk_strap_role: assert property (
        !strap_done_r |=> ctl_r[CTL_ROLE] == ($past(i_strap_mode) == STRAP_MEDIA))
        else $error("strap role wrong");

    cov_page_read: cover property (i_page_valid ##[1:4] rd_exp);
    cov_swreset: cover property (wr_ctl ##[1:4] wr_swr);
    cov_loopback: cover property (ctl_r[CTL_LOOPBACK] && o_link_up);
    cov_irq: cover property (o_irq ##1 wr_ists);
endmodule : serial_an_regs

// ===== serial_an_pkg.sv
// constants for the serial interface negotiation control and status bank
// assumes a plain register port on one 100 MHz clock
// What this block does
// - expansion bit 3 shows partner next-page ability
// - expansion bit 2 shows local next-page ability
// - expansion bit 1 latches high on page arrival
// - expansion bit 0 needs sync, three groups, enable
// - control bit 12 loops serial input to output
// - control bit 10 forces the link up
// - control bit 9 resets to one, allows bypass
// - bypass bit acts only after software reset
// - role bit loads one when straps equal 101
// - role bit acts at strap load, otherwise only after software reset
package serial_an_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [4:0] ADDR_EXPANSION = 5'h06;
    localparam logic [4:0] ADDR_CONTROL_ONE = 5'h10;
    localparam logic [4:0] ADDR_SWRESET = 5'h18;
    localparam logic [4:0] ADDR_INT_STATUS = 5'h19;
    localparam logic [4:0] ADDR_INT_MASK = 5'h1A;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int EXP_LP_NP = 3;
    localparam int EXP_LOCAL_NP = 2;
    localparam int EXP_PAGE_RX = 1;
    localparam int EXP_LP_AN = 0;
    localparam int CTL_LOOPBACK = 12;
    localparam int CTL_FORCE_LINK = 10;
    localparam int CTL_BYPASS = 9;
    localparam int CTL_ROLE = 0;
    localparam int SWR_GO = 0;
    localparam int EV_PAGE = 0;
    localparam int EV_LP_AN = 1;
    localparam int EV_LINK = 2;
    // ------------------------------------------------------------
    // reset values and counts
    // ------------------------------------------------------------
    localparam logic [15:0] CTL_RESET = 16'h0214;
    localparam logic [15:0] CTL_WMASK = 16'h1F3D;
    localparam logic [2:0] STRAP_MEDIA = 3'h5;
    localparam logic [1:0] MATCH_NEEDED = 2'h3;
    localparam logic [2:0] EV_ALL = 3'h7;
endpackage : serial_an_pkg

// ===== cfg_match_counter.sv
// counts matching nonzero configuration code groups
// assumes groups arrive as one-cycle strobes on the system clock
`timescale 1ns/1ps
module cfg_match_counter
    import serial_an_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_clear,
    input wire logic i_cfg_valid,
    input wire logic [15:0] i_cfg_word,
    output logic o_matched
);
    logic [1:0] cnt_r;
    logic [1:0] cnt_nxt;
    logic [15:0] last_r;
    logic [15:0] last_nxt;

    // run of identical nonzero words, saturating at three
    always_comb begin
        cnt_nxt = cnt_r;
        last_nxt = last_r;
        if (i_clear) begin
            cnt_nxt = 2'h0;
        end else if (i_cfg_valid) begin
            last_nxt = i_cfg_word;
            if (i_cfg_word == 16'h0000) begin
                cnt_nxt = 2'h0;
            end else if (i_cfg_word != last_r || cnt_r == 2'h0) begin
                cnt_nxt = 2'h1;
            end else if (cnt_r != MATCH_NEEDED) begin
                cnt_nxt = cnt_r + 2'h1;
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_r <= 2'h0;
            last_r <= 16'h0000;
        end else begin
            cnt_r <= cnt_nxt;
            last_r <= last_nxt;
        end
    end

    assign o_matched = (cnt_r == MATCH_NEEDED);
endmodule : cfg_match_counter

// ===== serial_peer_model.sv
// peer serial port model facing the negotiation bank
// assumes the bench calls its tasks right after a rising clock edge
`timescale 1ns/1ps
module serial_peer_model (
    input wire logic i_sys_clk,
    output logic o_sync = 1'b1,
    output logic o_link_sm_up = 1'b0,
    output logic o_page_valid = 1'b0,
    output logic o_lp_np_able = 1'b0,
    output logic o_cfg_valid = 1'b0,
    output logic [15:0] o_cfg_word = 16'hFFFF,
    output logic [9:0] o_serial_rx = 10'h000
);
    // ------------------------------------------------------------
    // receive data and negotiation traffic
    // ------------------------------------------------------------
    // line data changes every cycle so a stale copy is visible
    always @(posedge i_sys_clk) begin
        o_serial_rx <= o_serial_rx + 10'h13B;
    end

    // one valid page strobe; partner next-page bit only beside it
    task automatic send_page(input logic np);
        @(posedge i_sys_clk);
        o_page_valid <= 1'b1;
        o_lp_np_able <= np;
        @(posedge i_sys_clk);
        o_page_valid <= 1'b0;
        o_lp_np_able <= ~np;
    endtask : send_page

    // n back-to-back code groups, word scrambled when not valid
    task automatic send_cfg(input logic [15:0] w, input int n);
        for (int k = 0; k < n; k++) begin
            @(posedge i_sys_clk);
            o_cfg_valid <= 1'b1;
            o_cfg_word <= w;
        end
        @(posedge i_sys_clk);
        o_cfg_valid <= 1'b0;
        o_cfg_word <= ~w;
    endtask : send_cfg
endmodule : serial_peer_model

// ===== serial_an_regs_tb.sv
// self-checking bench of the serial negotiation control and status bank
// assumes the package, design and peer model are compiled first
`timescale 1ns/1ps
module serial_an_regs_tb
    import serial_an_pkg::*;
;
    // ------------------------------------------------------------
    // stimulus and wiring
    // ------------------------------------------------------------
    logic i_sys_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [4:0] i_addr = 5'h00;
    logic [15:0] i_wdata = 16'h0000;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic i_an_enable = 1'b0;
    logic i_local_np_able = 1'b1;
    logic [2:0] strap = 3'h5;
    logic [9:0] i_core_tx = 10'h2A5;
    logic [15:0] o_rdata;
    logic [9:0] o_serial_tx;
    logic o_link_up, o_bypass_active, o_media_role, o_irq;
    logic sync, link_sm_up, page_valid, lp_np, cfg_valid;
    logic [15:0] cfg_word;
    logic [9:0] serial_rx;
    int n_errors = 0;
    int check_count = 0;

    always #5 i_sys_clk = ~i_sys_clk;

    serial_peer_model peer (.i_sys_clk(i_sys_clk), .o_sync(sync), .o_link_sm_up(link_sm_up),
        .o_page_valid(page_valid), .o_lp_np_able(lp_np), .o_cfg_valid(cfg_valid),
        .o_cfg_word(cfg_word), .o_serial_rx(serial_rx));

    serial_an_regs DUT (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_strap_mode(strap), .i_sync(sync), .i_link_sm_up(link_sm_up),
        .i_an_enable(i_an_enable), .i_local_np_able(i_local_np_able),
        .i_page_valid(page_valid), .i_lp_np_able(lp_np), .i_cfg_valid(cfg_valid),
        .i_cfg_word(cfg_word), .i_serial_rx(serial_rx), .i_core_tx(i_core_tx),
        .o_serial_tx(o_serial_tx), .o_link_up(o_link_up), .o_bypass_active(o_bypass_active),
        .o_media_role(o_media_role), .o_irq(o_irq));

    // ------------------------------------------------------------
    // bus cycles and comparison
    // ------------------------------------------------------------
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge i_sys_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask : rd

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask : check

    task automatic print_verdict();
        if (n_errors == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset_values();
        logic [15:0] d;
        rd(ADDR_CONTROL_ONE, d);
        check("control", d, 16'h0215);
        check("bypass", {15'h0, o_bypass_active}, 16'h0001);
        check("role", {15'h0, o_media_role}, 16'h0001);
        rd(ADDR_EXPANSION, d);
        check("expansion", d, 16'h0004);
        rd(5'h03, d);
        check("unmapped", d, 16'h0000);
    endtask : t_reset_values

    task automatic t_page();
        logic [15:0] d;
        peer.send_page(1'b1);
        rd(ADDR_EXPANSION, d);
        check("page np", d, 16'h000E);
        rd(ADDR_EXPANSION, d);
        check("page cleared", d, 16'h000C);
        peer.send_page(1'b0);
        rd(ADDR_EXPANSION, d);
        check("page no np", d, 16'h0006);
    endtask : t_page

    task automatic t_irq();
        logic [15:0] d;
        wr(ADDR_INT_STATUS, 16'h0007);
        wr(ADDR_INT_MASK, 16'h0001);
        #1 check("irq idle", {15'h0, o_irq}, 16'h0000);
        peer.send_page(1'b0);
        #1 check("irq set", {15'h0, o_irq}, 16'h0001);
        wr(ADDR_INT_STATUS, 16'h0001);
        #1 check("irq clear", {15'h0, o_irq}, 16'h0000);
        wr(ADDR_INT_MASK, 16'h0000);
        peer.send_page(1'b0);
        #1 check("irq masked", {15'h0, o_irq}, 16'h0000);
        wr(ADDR_INT_STATUS, 16'h0007);
        rd(ADDR_EXPANSION, d);
    endtask : t_irq

    task automatic t_match();
        logic [15:0] d;
        @(posedge i_sys_clk);
        i_an_enable <= 1'b1;
        repeat (4) @(posedge i_sys_clk);
        peer.send_cfg(16'h4001, 2);
        rd(ADDR_EXPANSION, d);
        check("two groups", d, 16'h0004);
        peer.send_cfg(16'h4001, 1);
        rd(ADDR_EXPANSION, d);
        check("three groups", d, 16'h0005);
        @(posedge i_sys_clk);
        i_an_enable <= 1'b0;
        repeat (4) @(posedge i_sys_clk);
        rd(ADDR_EXPANSION, d);
        check("an disabled", d, 16'h0004);
    endtask : t_match

    task automatic t_data_path();
        logic [9:0] r;
        wr(ADDR_CONTROL_ONE, 16'h1615);
        #1 r = serial_rx;
        @(posedge i_sys_clk);
        #1 check("loopback", {6'h0, o_serial_tx}, {6'h0, r});
        check("forced link", {15'h0, o_link_up}, 16'h0001);
        wr(ADDR_CONTROL_ONE, 16'h0215);
        @(posedge i_sys_clk);
        #1 check("normal tx", {6'h0, o_serial_tx}, 16'h02A5);
        check("link down", {15'h0, o_link_up}, 16'h0000);
    endtask : t_data_path

    task automatic t_swreset();
        logic [15:0] d;
        wr(ADDR_CONTROL_ONE, 16'h1014);
        repeat (2) @(posedge i_sys_clk);
        #1 check("bypass held", {15'h0, o_bypass_active}, 16'h0001);
        check("role held", {15'h0, o_media_role}, 16'h0001);
        wr(ADDR_SWRESET, 16'h0001);
        @(posedge i_sys_clk);
        #1 check("bypass new", {15'h0, o_bypass_active}, 16'h0000);
        check("role new", {15'h0, o_media_role}, 16'h0000);
        rd(ADDR_CONTROL_ONE, d);
        check("control after", d, 16'h0014);
    endtask : t_swreset

    // mid-run hardware reset with straps away from media role
    task automatic t_strap();
        logic [15:0] d;
        @(posedge i_sys_clk);
        i_rst_n <= 1'b0;
        strap <= 3'h4;
        repeat (3) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        rd(ADDR_CONTROL_ONE, d);
        check("control strap", d, 16'h0214);
        check("role strap", {15'h0, o_media_role}, 16'h0000);
        check("bypass reset", {15'h0, o_bypass_active}, 16'h0001);
    endtask : t_strap

    // ------------------------------------------------------------
    // main sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        repeat (20) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        t_reset_values();
        t_page();
        t_irq();
        t_match();
        t_data_path();
        t_swreset();
        t_strap();
        print_verdict();
    end

    // cuts a hang short and counts it as a mismatch
    initial begin
        repeat (20000) @(posedge i_sys_clk);
        n_errors++;
        print_verdict();
    end
endmodule : serial_an_regs_tb
